// ---- verilog/host_indirect_memory_port.sv ----
`timescale 1ns/100ps
// Summary of operation
// - pointer bits 7..0 form local address bits 7..0 on every data window access.
// - upper pointer bits 6..0 form local address bits 14..8 on every window access.
// - each window read or write advances the whole 15-bit pointer by one.
// - the upper pointer byte advances only on a carry out of the low byte.
// - local address bits 16..15 come from the two memory bank bits.
// - a window access moves one byte to or from the memory chosen by pointer, bank and flash bits.
// - all four windows are aliases sharing one pointer with no added offset.
// - the pointer registers hold their contents through any reset.
// - in plug-and-play mode writing one to the power-down bit raises the controller flag.
// - the power-down bit reads zero after a request and one while powered down.
// - writing zero to the power-down bit while powered down requests exit.
// - in card mode the power-down bit is ignored on writes and reads back zero.
// - flash select set sends accesses to flash, cleared sends them to sram.
// - the controller power-down flag sets on a host request and clears on a controller one.

// command buffer between host windows and the local memory bus
module cmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  wire              push;
  wire              pop;

  // full when pointers differ only in the wrap bit
  assign in_ready  = !((wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]));
  assign out_valid = (wr_reg != rd_reg);
  assign out_data  = store[rd_reg[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // storage has no reset, only the pointers need a defined start
  always_ff @(posedge clk) begin
    if (push) begin
      store[wr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop)  rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule

module host_indirect_memory_port (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // host register port
  input  wire logic        host_valid,
  output logic             host_ready,
  input  wire logic        host_write,
  input  wire logic [2:0]  host_addr,
  input  wire logic [7:0]  host_wdata,
  output logic             host_rvalid,
  output logic [7:0]       host_rdata,
  // bank switching and mode inputs
  input  wire logic [1:0]  memory_bank_bits,
  input  wire logic        flash_select,
  input  wire logic        isa_pnp_mode,
  // local memory command side
  output logic             mem_cmd_valid,
  input  wire logic        mem_cmd_ready,
  output host_port_pkg::mem_cmd_type mem_cmd,
  input  wire logic        mem_rvalid,
  input  wire logic [7:0]  local_mem_data_bus,
  // power-down handshake with the controller
  input  wire logic        powerdown_active,
  input  wire logic        ctrl_flag_clear,
  output logic             sys_powerdown_flag,
  output logic             powerdown_exit_req
);

  logic [7:0]                ptr_low_reg;
  logic [6:0]                ptr_high_reg;
  logic [1:0]                mode_sync_reg;
  logic                      flag_reg;
  logic                      exit_reg;
  logic                      rvalid_reg;
  logic [7:0]                rdata_reg;
  logic [4:0]                pending_reg;
  host_port_pkg::mem_cmd_type in_cmd;
  wire                       isa_mode;
  wire                       is_window;
  wire                       fifo_ready;
  wire                       accept;
  wire                       win_acc;
  wire                       reg_read;
  wire                       pd_write;
  wire                       pd_req;
  wire                       carry;
  wire [7:0]                 high_read;
  wire [7:0]                 reg_rdata;

  // a window is any of the four aliased slots
  function automatic logic window_hit(input logic [2:0] a);
    window_hit = (a >= host_port_pkg::REG_WINDOW_1ST) &&
                 (a <= host_port_pkg::REG_WINDOW_4TH);
  endfunction

  // mode strap arrives from a pin, so it is synchronised first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_sync_reg <= host_port_pkg::SYNC_RESET;
    end else begin
      mode_sync_reg <= {mode_sync_reg[0], isa_pnp_mode};
    end
  end
  assign isa_mode = mode_sync_reg[1];

  // request decode; register reads wait until queued window reads drain
  assign is_window  = window_hit(host_addr);
  assign host_ready = is_window ? fifo_ready : (pending_reg == '0);
  assign accept     = host_valid && host_ready;
  assign win_acc    = accept && is_window;
  assign reg_read   = accept && !is_window && !host_write;
  assign pd_write   = accept && host_write && (host_addr == host_port_pkg::REG_PTR_HIGH)
                      && isa_mode;
  assign pd_req     = pd_write && host_wdata[host_port_pkg::PD_BIT_POS];
  assign carry      = &ptr_low_reg;

  // command built from the pointer value before it advances
  assign in_cmd.write = host_write;
  assign in_cmd.flash = flash_select;
  assign in_cmd.addr  = {memory_bank_bits, ptr_high_reg, ptr_low_reg};
  assign in_cmd.data  = host_wdata;

  cmd_fifo #(
    .WIDTH (host_port_pkg::CMD_WIDTH),
    .DEPTH (host_port_pkg::FIFO_DEPTH)
  ) cmd_fifo_inst (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (host_valid && is_window),
    .in_ready  (fifo_ready),
    .in_data   (in_cmd),
    .out_valid (mem_cmd_valid),
    .out_ready (mem_cmd_ready),
    .out_data  (mem_cmd)
  );

  // pointer has no reset so software state survives any reset
  always_ff @(posedge clk) begin
    if (win_acc) begin
      ptr_low_reg <= ptr_low_reg + 8'h01;
      if (carry) ptr_high_reg <= ptr_high_reg + 7'h01;
    end else if (accept && host_write && host_addr == host_port_pkg::REG_PTR_LOW) begin
      ptr_low_reg <= host_wdata;
    end else if (accept && host_write && host_addr == host_port_pkg::REG_PTR_HIGH) begin
      ptr_high_reg <= host_wdata[host_port_pkg::PTR_HIGH_MSB:0];
    end
  end

  // power-down bit reads as current state; card mode reads zero
  assign high_read = {isa_mode && powerdown_active, ptr_high_reg};
  assign reg_rdata = (host_addr == host_port_pkg::REG_PTR_LOW)  ? ptr_low_reg :
                     (host_addr == host_port_pkg::REG_PTR_HIGH) ? high_read : 8'h00;

  // read answers: register reads next cycle, window reads on memory return
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 8'h00;
    end else begin
      rvalid_reg <= reg_read || mem_rvalid;
      if (mem_rvalid) begin
        rdata_reg <= local_mem_data_bus;
      end else if (reg_read) begin
        rdata_reg <= reg_rdata;
      end
    end
  end
  assign host_rvalid = rvalid_reg;
  assign host_rdata  = rdata_reg;

  // count window reads still owed an answer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pending_reg <= host_port_pkg::COUNT_RESET;
    end else begin
      pending_reg <= pending_reg + {4'h0, win_acc && !host_write} - {4'h0, mem_rvalid};
    end
  end

  // flag: a new request wins over a simultaneous controller clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flag_reg <= host_port_pkg::FLAG_RESET;
      exit_reg <= host_port_pkg::FLAG_RESET;
    end else begin
      flag_reg <= pd_req || (flag_reg && !ctrl_flag_clear);
      exit_reg <= pd_write && !host_wdata[host_port_pkg::PD_BIT_POS]
                  && powerdown_active;
    end
  end
  assign sys_powerdown_flag = flag_reg;
  assign powerdown_exit_req = exit_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // judged at the buffer output, so a slip anywhere in the command path shows up
  property p_addr_low;
    win_acc && !mem_cmd_valid |=> mem_cmd.addr[7:0] == $past(ptr_low_reg);
  endproperty
  a_addr_low: assert property (p_addr_low) else $error("low address mismatch");

  property p_addr_high;
    win_acc && !mem_cmd_valid |=> mem_cmd.addr[14:8] == $past(ptr_high_reg);
  endproperty
  a_addr_high: assert property (p_addr_high) else $error("high address mismatch");

  property p_incr;
    win_acc |=> {ptr_high_reg, ptr_low_reg} == $past({ptr_high_reg, ptr_low_reg}) + 15'h0001;
  endproperty
  a_incr: assert property (p_incr) else $error("pointer did not advance");

  property p_no_carry;
    win_acc && ptr_low_reg != 8'hff |=> ptr_high_reg == $past(ptr_high_reg);
  endproperty
  a_no_carry: assert property (p_no_carry) else $error("upper byte moved");

  property p_bank;
    win_acc && !mem_cmd_valid |=> mem_cmd.addr[16:15] == $past(memory_bank_bits)
      && mem_cmd.flash == $past(flash_select);
  endproperty
  a_bank: assert property (p_bank) else $error("bank or flash select wrong");

  property p_read_return;
    mem_rvalid |=> host_rvalid && host_rdata == $past(local_mem_data_bus);
  endproperty
  a_read_return: assert property (p_read_return) else $error("read data lost");

  property p_pd_set;
    pd_req |=> sys_powerdown_flag [*2] or (sys_powerdown_flag ##1 $past(ctrl_flag_clear));
  endproperty
  a_pd_set: assert property (p_pd_set) else $error("flag not raised");

  property p_pd_read;
    reg_read && host_addr == host_port_pkg::REG_PTR_HIGH |=>
      host_rdata[7] == ($past(isa_mode) && $past(powerdown_active));
  endproperty
  a_pd_read: assert property (p_pd_read) else $error("power-down bit readback");

  property p_exit;
    pd_write && !host_wdata[7] && powerdown_active |=> powerdown_exit_req ##1 !powerdown_exit_req;
  endproperty
  a_exit: assert property (p_exit) else $error("exit not requested");

  property p_flag_hold;
    sys_powerdown_flag && !ctrl_flag_clear |=> sys_powerdown_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

  c_wrap:  cover property (win_acc && {ptr_high_reg, ptr_low_reg} == 15'h7fff);
  c_full:  cover property (host_valid && is_window && !fifo_ready);
  c_pdreq: cover property (pd_req ##[1:20] ctrl_flag_clear);
endmodule

// ---- verilog/host_port_pkg.sv ----
package host_port_pkg;

  // host register slots, indexed by the host port address
  localparam logic [2:0] REG_PTR_LOW    = 3'h2;
  localparam logic [2:0] REG_PTR_HIGH   = 3'h3;
  localparam logic [2:0] REG_WINDOW_1ST = 3'h4;
  localparam logic [2:0] REG_WINDOW_4TH = 3'h7;

  // field positions
  localparam int PD_BIT_POS      = 7;
  localparam int PTR_HIGH_MSB    = 6;
  localparam int PTR_WIDTH       = 15;
  localparam int MEM_ADDR_WIDTH  = 17;

  // reset values
  localparam logic       FLAG_RESET  = 1'b0;
  localparam logic [1:0] SYNC_RESET  = 2'b00;
  localparam logic [4:0] COUNT_RESET = 5'h00;

  // command buffer shape
  localparam int FIFO_DEPTH = 16;

  // one queued local memory access
  typedef struct packed {
    logic                      write;
    logic                      flash;
    logic [MEM_ADDR_WIDTH-1:0] addr;
    logic [7:0]                data;
  } mem_cmd_type;

  localparam int CMD_WIDTH = $bits(mem_cmd_type);

endpackage

// ---- tb/local_mem_model.sv ----
`timescale 1ns/100ps
// local memory stand-in: takes queued commands and answers reads in order
module local_mem_model (
  // clock
  input  wire logic                 clk,
  // command side
  input  wire logic                 mem_cmd_valid,
  output logic                      mem_cmd_ready,
  input  wire host_port_pkg::mem_cmd_type mem_cmd,
  output logic                      mem_rvalid,
  output logic [7:0]                local_mem_data_bus,
  // bench controls
  input  wire logic                 stall,
  input  wire logic                 slow,
  output host_port_pkg::mem_cmd_type last_cmd
);
  logic [7:0]  store [logic [17:0]];
  logic [7:0]  rq [$];
  logic [17:0] k;
  logic [1:0]  tick = 2'h0;
  assign mem_cmd_ready = !stall;
  initial begin
    mem_rvalid = 1'b0;
    local_mem_data_bus = 8'h00;
  end
  // unwritten places answer the inverted low address; idle bus toggles, not holds
  always @(posedge clk) begin
    tick <= tick + 2'h1;
    if (mem_cmd_valid && !stall) begin
      k = {mem_cmd.flash, mem_cmd.addr};
      last_cmd <= mem_cmd;
      if (mem_cmd.write) store[k] = mem_cmd.data;
      else rq.push_back(store.exists(k) ? store[k] : ~k[7:0]);
    end
    if (rq.size() != 0 && (!slow || tick == 2'h0)) begin
      mem_rvalid <= 1'b1;
      local_mem_data_bus <= rq.pop_front();
    end else begin
      mem_rvalid <= 1'b0;
      local_mem_data_bus <= ~local_mem_data_bus;
    end
  end
endmodule

// ---- tb/tb_host_indirect_memory_port.sv ----
`timescale 1ns/100ps
module tb_host_indirect_memory_port;
  logic       clk = 1'b0, nrst = 1'b0, host_valid = 1'b0, host_write = 1'b0;
  logic [2:0] host_addr = 3'h0;
  logic [7:0] host_wdata = 8'h00, host_rdata, local_mem_data_bus, rd;
  logic [1:0] memory_bank_bits = 2'h0;
  logic       flash_select = 1'b0, isa_pnp_mode = 1'b1, powerdown_active = 1'b0;
  logic       ctrl_flag_clear = 1'b0, stall = 1'b0, slow = 1'b0;
  logic       host_ready, host_rvalid, mem_cmd_valid, mem_cmd_ready, mem_rvalid;
  logic       sys_powerdown_flag, powerdown_exit_req;
  host_port_pkg::mem_cmd_type mem_cmd, last_cmd;
  int         miscompares = 0, cmp_count = 0, exits = 0;

  host_indirect_memory_port host_indirect_memory_port_inst (.clk, .nrst, .host_valid,
    .host_ready, .host_write, .host_addr, .host_wdata, .host_rvalid, .host_rdata,
    .memory_bank_bits, .flash_select, .isa_pnp_mode, .mem_cmd_valid, .mem_cmd_ready,
    .mem_cmd, .mem_rvalid, .local_mem_data_bus, .powerdown_active, .ctrl_flag_clear,
    .sys_powerdown_flag, .powerdown_exit_req);
  local_mem_model local_mem_model_inst (.clk, .mem_cmd_valid, .mem_cmd_ready, .mem_cmd,
    .mem_rvalid, .local_mem_data_bus, .stall, .slow, .last_cmd);

  // clock and exit-pulse counter; the pulse lasts one cycle so it is counted at the edge
  always #25 clk = ~clk;
  always @(posedge clk) if (powerdown_exit_req === 1'b1) exits++;

  // single comparison point
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // one host access; request held until taken, read answer captured into rd
  task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] d);
    int n = 0;
    @(negedge clk);
    host_valid = 1'b1;
    host_write = wr;
    host_addr = a;
    host_wdata = d;
    #1;
    while (host_ready !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    host_valid = 1'b0;
    if (!wr) while (host_rvalid !== 1'b1 && n < 80) begin
      @(negedge clk);
      n++;
    end
    rd = host_rdata;
    chk("handshake", n < 80, 1'b1);
  endtask

  // aliased windows across the pointer wrap, then read back slowly in reverse window order
  task automatic t_windows();
    logic [7:0]  d [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
    logic [14:0] p;
    memory_bank_bits = 2'h2;
    flash_select = 1'b1;
    xfer(1'b1, 3'h2, 8'hFE);
    xfer(1'b1, 3'h3, 8'h7F);
    for (int i = 0; i < 4; i++) begin
      p = 15'h7FFE + 15'(i);
      xfer(1'b1, 3'(4 + i), d[i]);
      repeat (3) @(negedge clk);
      chk("cmd addr", 32'(last_cmd.addr), {2'h2, p});
      chk("cmd data", {last_cmd.write, last_cmd.flash, last_cmd.data}, {2'h3, d[i]});
    end
    xfer(1'b0, 3'h2, 8'h00);
    chk("ptr low", rd, 8'h02);
    xfer(1'b0, 3'h3, 8'h00);
    chk("ptr high", rd, 8'h00);
    slow = 1'b1;
    xfer(1'b1, 3'h2, 8'hFE);
    xfer(1'b1, 3'h3, 8'h7F);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 3'(7 - i), 8'h00);
      chk("window read", rd, d[i]);
    end
    flash_select = 1'b0;
    xfer(1'b1, 3'h2, 8'hFE);
    xfer(1'b1, 3'h3, 8'h7F);
    xfer(1'b0, 3'h4, 8'h00);
    chk("sram read", rd, 8'h01);
    slow = 1'b0;
    $display("windows done");
  endtask

  // memory side stalls until the command buffer refuses, then drains
  task automatic t_fill();
    int n = 0;
    stall = 1'b1;
    @(negedge clk);
    host_valid = 1'b1;
    host_write = 1'b1;
    host_addr = 3'h5;
    #1;
    repeat (24) begin
      if (host_ready === 1'b1) n++;
      @(negedge clk);
    end
    host_valid = 1'b0;
    chk("accepted", n, 32'h0000_0010);
    stall = 1'b0;
    repeat (20) @(negedge clk);
    chk("drained", mem_cmd_valid, 1'b0);
    $display("fill done");
  endtask

  // power-down request, controller clear, exit, and card mode
  task automatic t_power();
    xfer(1'b1, 3'h3, 8'h80);
    @(negedge clk);
    chk("flag set", sys_powerdown_flag, 1'b1);
    xfer(1'b0, 3'h3, 8'h00);
    chk("bit pending", rd[7], 1'b0);
    ctrl_flag_clear = 1'b1;
    @(negedge clk) ctrl_flag_clear = 1'b0;
    @(negedge clk);
    chk("flag clear", sys_powerdown_flag, 1'b0);
    powerdown_active = 1'b1;
    xfer(1'b0, 3'h3, 8'h00);
    chk("bit powered down", rd[7], 1'b1);
    xfer(1'b1, 3'h3, 8'h00);
    repeat (2) @(negedge clk);
    chk("exit pulses", exits, 1);
    isa_pnp_mode = 1'b0;
    repeat (4) @(negedge clk);
    xfer(1'b1, 3'h3, 8'h00);
    repeat (2) @(negedge clk);
    chk("card exit", exits, 1);
    chk("card flag", sys_powerdown_flag, 1'b0);
    powerdown_active = 1'b0;
    isa_pnp_mode = 1'b1;
    $display("power done");
  endtask

  // pointer survives a reset in mid-run
  task automatic t_reset();
    xfer(1'b1, 3'h2, 8'h34);
    xfer(1'b1, 3'h3, 8'h12);
    @(negedge clk) nrst = 1'b0;
    @(negedge clk);
    chk("reset state", {host_ready, mem_cmd_valid, host_rvalid}, 3'h4);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    xfer(1'b0, 3'h2, 8'h00);
    chk("low kept", rd, 8'h34);
    xfer(1'b0, 3'h3, 8'h00);
    chk("high kept", rd, 8'h12);
    $display("reset done");
  endtask

  // main sequence
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    t_windows();
    t_fill();
    t_power();
    t_reset();
    close_out();
  end

  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #2_000_000;
    miscompares++;
    close_out();
  end
endmodule
